// File: core/cbp_pkg.sv
// Package of constants and types for the configuration bitstream frame parser.
// How it works
// - Header: leading ones, then preamble 0010.
// - 24-bit length field follows the preamble.
// - ID frame mandatory; checks device identity.
// - Every frame but the postamble checked against trailing checksum byte.
// - ID frame mode bit picks addressing.
// - Data frame: start pair, byte-aligned stop bits.
// - Autoincrement stores frames at consecutive addresses.
// - Explicit: address frames store preceding data.
// - Postamble: max address, all-ones checksum, ends.
// - No start while hold or program asserted.
// - Errors park in the error state, hold line driven low.
// - Zero stop bit before start pair: alignment error.
// - Address frame: 00, 14-bit address, checksum.
// - Mode field: 00 autoincrement, 01 explicit.
package cbp_pkg;

  // ***************************************************************
  // Frame layout
  // ***************************************************************
  localparam int          LEN_W      = 24;
  localparam int          ADDR_W     = 14;
  localparam int          DATA_BITS  = 64;
  localparam int          DATA_PAD   = 6;
  localparam int          ID_W       = 20;
  localparam int          SHIFT_W    = 80;
  localparam int          CNT_W      = 7;
  localparam logic [4:0]  PREAMBLE   = 5'h12;    // One lead bit then 0010.
  localparam logic [6:0]  LEN_LAST   = 7'h17;    // Bit index of last length bit.
  localparam logic [6:0]  BYTE_LAST  = 7'h07;    // Last bit of a byte.
  localparam logic [6:0]  ID_BODY    = 7'h4e;    // 14 fixed + 2 mode + 42 rsvd + 20 id.
  localparam logic [6:0]  DATA_BODY  = 7'h46;    // Data bits plus alignment zeros.
  localparam logic [6:0]  ADDR_BODY  = 7'h0e;
  localparam int          ID_HDR_MSB = 77;
  localparam int          ID_HDR_LSB = 64;
  localparam int          MODE_MSB   = 63;
  localparam int          MODE_LSB   = 62;
  localparam logic [13:0] ID_HDR_ONES = 14'h3fff;
  localparam logic [13:0] ADDR_MAX   = 14'h3fff;
  localparam logic [7:0]  POST_CHK   = 8'hff;
  localparam logic [1:0]  MODE_AUTO  = 2'h0;
  localparam logic [1:0]  MODE_EXPL  = 2'h1;
  localparam logic [19:0] DEVICE_ID  = 20'h5a3c1;  // Arbitrary value.

  typedef enum {
    CBP_IDLE, CBP_LEAD, CBP_LEN, CBP_STOP, CBP_HUNT,
    CBP_PAIR, CBP_BODY, CBP_CHK, CBP_DONE, CBP_ERR
  } cbp_state_e;

  typedef enum {CBP_F_ID, CBP_F_DATA, CBP_F_ADDR} cbp_frame_e;

endpackage

// File: core/cbp_chk_acc.sv
// Byte-wise checksum accumulator fed one bit at a time, MSB first.
`timescale 1ns/1ps
module cbp_chk_acc (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       clear,
  input  wire logic       bit_valid,
  input  wire logic       bit_in,
  output logic [7:0]      sum
);
  import cbp_pkg::*;

  logic [6:0] part;
  logic [2:0] idx;
  logic [6:0] next_part;
  logic [2:0] next_idx;
  logic [7:0] next_sum;

  // ***************************************************************
  // Accumulate
  // ***************************************************************
  // Frames are whole bytes, so the sum is complete when the body ends.
  always_comb begin
    next_part = part;
    next_idx  = idx;
    next_sum  = sum;
    if (clear) begin
      next_part = 7'h00;
      next_idx  = 3'h0;
      next_sum  = 8'h00;
    end else if (bit_valid) begin
      next_part = {part[5:0], bit_in};
      next_idx  = idx + 3'h1;
      if (idx == 3'h7) begin
        next_sum = sum + {part, bit_in};
      end
    end
  end

  // Register the accumulator state.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      part <= 7'h00;
      idx  <= 3'h0;
      sum  <= 8'h00;
    end else begin
      part <= next_part;
      idx  <= next_idx;
      sum  <= next_sum;
    end
  end

endmodule // cbp_chk_acc

// File: core/cbp_parser.sv
// Serial configuration bitstream frame parser, top level.
`timescale 1ns/1ps
module cbp_parser (
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  input  wire logic                         cfg_clk_pin,
  input  wire logic                         cfg_din,
  input  wire logic                         program_request_n,
  input  wire logic                         init_in,
  output logic                              init_out,
  output logic                              init_oe,
  output logic                              cfg_we,
  output logic [cbp_pkg::ADDR_W-1:0]        cfg_addr,
  output logic [cbp_pkg::DATA_BITS-1:0]     cfg_data,
  output logic                              load_done,
  output logic                              mode_explicit,
  output logic                              err_id,
  output logic                              err_align,
  output logic                              err_crc
);
  import cbp_pkg::*;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  // Clock, data, program and hold pins all pass two flops; data and
  // clock share the same delay, so data is sampled at the clock's rise.
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       cclk_d;
  logic       edge_s;
  logic       b;
  logic       prog;
  logic       hold_ok;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sync1  <= 4'hc;
      sync2  <= 4'hc;
      cclk_d <= 1'b0;
    end else begin
      sync1  <= {init_in, program_request_n, cfg_din, cfg_clk_pin};
      sync2  <= sync1;
      cclk_d <= sync2[0];
    end
  end

  assign edge_s  = sync2[0] & ~cclk_d;
  assign b       = sync2[1];
  assign prog    = ~sync2[2];
  assign hold_ok = sync2[3];

  // ***************************************************************
  // Parser state
  // ***************************************************************
  cbp_state_e           state, next_state;
  cbp_frame_e           ftype, next_ftype;
  logic [SHIFT_W-1:0]   sh, next_sh;
  logic [CNT_W-1:0]     cnt, next_cnt;
  logic [7:0]           chk, next_chk;
  logic                 stop_bad, next_stop_bad;
  logic                 id_seen, next_id_seen;
  logic                 next_mode_explicit;
  logic [ADDR_W-1:0]    waddr, next_waddr;
  logic [DATA_BITS-1:0] dbuf, next_dbuf;
  logic [LEN_W-1:0]     len, next_len;
  logic [LEN_W-1:0]     cyc, next_cyc;
  logic                 len_valid, next_len_valid;
  logic                 next_we;
  logic [ADDR_W-1:0]    next_addr;
  logic [DATA_BITS-1:0] next_data;
  logic                 next_err_id, next_err_align, next_err_crc;
  logic [7:0]           sum;
  logic [7:0]           cb;
  logic                 acc_clear;
  logic                 acc_valid;

  // Body length of each frame kind, used for counting the body bits.
  function automatic logic [CNT_W-1:0] body_len(input cbp_frame_e f);
    body_len = (f == CBP_F_ID) ? ID_BODY : (f == CBP_F_DATA) ? DATA_BODY : ADDR_BODY;
  endfunction

  // The sum restarts between frames and sees every bit from the start pair.
  assign acc_clear = (state == CBP_STOP);
  assign acc_valid = edge_s & ((state == CBP_HUNT & ~b) | state == CBP_PAIR |
                               state == CBP_BODY);
  assign cb        = {chk[6:0], b};

  cbp_chk_acc u_acc (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clear     (acc_clear),
    .bit_valid (acc_valid),
    .bit_in    (b),
    .sum       (sum)
  );

  // Next-state logic: one step per rising edge of the configuration clock.
  always_comb begin
    next_state         = state;
    next_ftype         = ftype;
    next_sh            = sh;
    next_cnt           = cnt;
    next_chk           = chk;
    next_stop_bad      = stop_bad;
    next_id_seen       = id_seen;
    next_mode_explicit = mode_explicit;
    next_waddr         = waddr;
    next_dbuf          = dbuf;
    next_len           = len;
    next_cyc           = cyc;
    next_len_valid     = len_valid;
    next_we            = 1'b0;
    next_addr          = cfg_addr;
    next_data          = cfg_data;
    next_err_id        = err_id;
    next_err_align     = err_align;
    next_err_crc       = err_crc;
    if (prog) begin
      // Program request clears any error and holds off a new load.
      next_state     = CBP_IDLE;
      next_err_id    = 1'b0;
      next_err_align = 1'b0;
      next_err_crc   = 1'b0;
      next_len_valid = 1'b0;
      next_id_seen   = 1'b0;
      // A new load picks its own mode, so the last one's choice is dropped.
      next_mode_explicit = 1'b0;
    end else if (state == CBP_IDLE) begin
      if (hold_ok) begin
        next_state = CBP_LEAD;
        next_sh    = '0;
      end
    end else if (edge_s) begin
      // The checksum byte stays out of the shifter so the body keeps its place.
      if (state != CBP_CHK) begin
        next_sh = {sh[SHIFT_W-2:0], b};
      end
      if (len_valid) begin
        next_cyc = cyc + 24'h000001;
      end
      case (state)
        CBP_LEAD: begin
          if (next_sh[4:0] == PREAMBLE) begin
            next_state = CBP_LEN;
            next_cnt   = '0;
            next_cyc   = '0;
          end
        end
        CBP_LEN: begin
          next_cnt = cnt + 7'h01;
          if (cnt == LEN_LAST) begin
            next_len       = next_sh[LEN_W-1:0];
            next_len_valid = 1'b1;
            next_cyc       = cyc + 24'h000001;
            next_state     = CBP_STOP;
            next_cnt       = '0;
            next_stop_bad  = 1'b0;
          end else begin
            next_cyc = cyc + 24'h000001;
          end
        end
        CBP_STOP: begin
          if (!b) begin
            next_stop_bad = 1'b1;
          end
          next_cnt = cnt + 7'h01;
          if (cnt == BYTE_LAST) begin
            next_state = CBP_HUNT;
          end
        end
        CBP_HUNT: begin
          if (!b) begin
            next_state = CBP_PAIR;
          end
        end
        CBP_PAIR: begin
          next_cnt = '0;
          if (stop_bad) begin
            next_state     = CBP_ERR;
            next_err_align = 1'b1;
          end else if (!id_seen) begin
            next_ftype = CBP_F_ID;
            next_state = b ? CBP_BODY : CBP_ERR;
            next_err_id = ~b;
          end else begin
            next_ftype = b ? CBP_F_DATA : CBP_F_ADDR;
            next_state = CBP_BODY;
          end
        end
        CBP_BODY: begin
          next_cnt = cnt + 7'h01;
          if (cnt == body_len(ftype) - 7'h01) begin
            next_state = CBP_CHK;
            next_cnt   = '0;
          end
        end
        CBP_CHK: begin
          next_chk = cb;
          next_cnt = cnt + 7'h01;
          if (cnt == BYTE_LAST) begin
            next_state    = CBP_STOP;
            next_cnt      = '0;
            next_stop_bad = 1'b0;
            if (ftype == CBP_F_ADDR && sh[ADDR_W-1:0] == ADDR_MAX && cb == POST_CHK) begin
              next_state = CBP_DONE;
            end else if (cb != sum) begin
              next_state   = CBP_ERR;
              next_err_crc = 1'b1;
            end else if (ftype == CBP_F_ID) begin
              if (sh[ID_HDR_MSB:ID_HDR_LSB] != ID_HDR_ONES || sh[ID_W-1:0] != DEVICE_ID ||
                  (sh[MODE_MSB:MODE_LSB] != MODE_AUTO &&
                   sh[MODE_MSB:MODE_LSB] != MODE_EXPL)) begin
                next_state  = CBP_ERR;
                next_err_id = 1'b1;
              end else begin
                next_id_seen       = 1'b1;
                next_mode_explicit = sh[MODE_LSB];
                next_waddr         = '0;
              end
            end else if (ftype == CBP_F_DATA) begin
              if (mode_explicit) begin
                next_dbuf = sh[DATA_BODY-1:DATA_PAD];
              end else begin
                next_we    = 1'b1;
                next_addr  = waddr;
                next_data  = sh[DATA_BODY-1:DATA_PAD];
                next_waddr = waddr + 14'h0001;
              end
            end else if (mode_explicit) begin
              next_we   = 1'b1;
              next_addr = sh[ADDR_W-1:0];
              next_data = dbuf;
            end else begin
              // An address frame in autoincrement mode rebases the counter.
              next_waddr = sh[ADDR_W-1:0];
            end
          end
        end
        default: begin
        end
      endcase
      // Judged after the frame steps so that only a step into the error state can block completion.
      if (len_valid && next_cyc == len && next_state != CBP_ERR && state != CBP_DONE) begin
        next_state = CBP_DONE;
      end
    end
  end

  // Register the parser state.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state         <= CBP_IDLE;
      ftype         <= CBP_F_ID;
      sh            <= '0;
      cnt           <= '0;
      chk           <= 8'h00;
      stop_bad      <= 1'b0;
      id_seen       <= 1'b0;
      mode_explicit <= 1'b0;
      waddr         <= '0;
      dbuf          <= '0;
      len           <= '0;
      cyc           <= '0;
      len_valid     <= 1'b0;
      cfg_we        <= 1'b0;
      cfg_addr      <= '0;
      cfg_data      <= '0;
      err_id        <= 1'b0;
      err_align     <= 1'b0;
      err_crc       <= 1'b0;
    end else begin
      state         <= next_state;
      ftype         <= next_ftype;
      sh            <= next_sh;
      cnt           <= next_cnt;
      chk           <= next_chk;
      stop_bad      <= next_stop_bad;
      id_seen       <= next_id_seen;
      mode_explicit <= next_mode_explicit;
      waddr         <= next_waddr;
      dbuf          <= next_dbuf;
      len           <= next_len;
      cyc           <= next_cyc;
      len_valid     <= next_len_valid;
      cfg_we        <= next_we;
      cfg_addr      <= next_addr;
      cfg_data      <= next_data;
      err_id        <= next_err_id;
      err_align     <= next_err_align;
      err_crc       <= next_err_crc;
    end
  end

  // ***************************************************************
  // Hold line and status
  // ***************************************************************
  // Open-drain hold line: only ever pulled low, in the error state.
  assign init_out  = 1'b0;
  assign init_oe   = (state == CBP_ERR);
  assign load_done = (state == CBP_DONE);

endmodule // cbp_parser

// File: bench/cbp_parser_chk.sv
// Concurrent checks on the frame parser's status and write outputs.
`timescale 1ns/1ps
module cbp_parser_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic program_request_n,
  input wire logic init_out,
  input wire logic init_oe,
  input wire logic cfg_we,
  input wire logic load_done,
  input wire logic mode_explicit,
  input wire logic err_id,
  input wire logic err_align,
  input wire logic err_crc
);
  // ***************************************************************
  // Helpers
  // ***************************************************************
  logic [2:0] errs;

  // The three flags are judged together because any of them parks the loader.
  assign errs = {err_id, err_align, err_crc};

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // ***************************************************************
  // Properties
  // ***************************************************************
  // The program pin passes a synchroniser, so its effect is judged six cycles on.
  we_pulse_a: assert property (cfg_we |=> !cfg_we)
    else $error("write strobe longer than one cycle");
  err_hold_a: assert property ($rose(|errs) |-> ##[0:1] init_oe)
    else $error("hold line not pulled on error");
  line_low_a: assert property (init_oe |-> !init_out)
    else $error("hold line driven high");
  err_quiet_a: assert property (init_oe |-> !cfg_we && !load_done)
    else $error("activity while parked on error");
  err_keep_a: assert property (program_request_n [*6] ##0 (errs != 3'h0)
    |=> (errs & $past(errs)) == $past(errs))
    else $error("error flag dropped without program");
  done_keep_a: assert property (program_request_n [*6] ##0 load_done |=> load_done)
    else $error("load done dropped without program");
  done_quiet_a: assert property (load_done && $past(load_done) |-> !cfg_we)
    else $error("write after load done");
  prog_idle_a: assert property ((!program_request_n) [*6]
    |-> !cfg_we && !load_done && errs == 3'h0)
    else $error("activity while program held");
  mode_hold_a: assert property (cfg_we |-> $stable(mode_explicit))
    else $error("mode changed during load");
endmodule // cbp_parser_chk

// File: bench/cbp_src.sv
// Behavioural configuration source that clocks a bit queue into the loader.
`timescale 1ns/1ps
module cbp_src (
  input  wire logic ref_clk,
  output logic      cfg_clk_pin,
  output logic      cfg_din
);
  // ***************************************************************
  // Serial sender
  // ***************************************************************
  // Idle with the clock low; the clock only runs within a stream.
  initial begin
    cfg_clk_pin = 1'b0;
    cfg_din     = 1'b0;
  end

  // Each bit is set up in the low phase and held through the high phase.
  task automatic send(input logic b[$], input int half);
    foreach (b[i]) begin
      cfg_din = b[i];
      repeat (half) @(posedge ref_clk);
      #1 cfg_clk_pin = 1'b1;
      repeat (half) @(posedge ref_clk);
      #1 cfg_clk_pin = 1'b0;
    end
    // Past its hold time the data line no longer shows the last bit.
    repeat (half) @(posedge ref_clk);
    #1 cfg_din = ~cfg_din;
  endtask
endmodule // cbp_src

// File: bench/cbp_parser_bench.sv
// Self-checking bench for the configuration bitstream frame parser.
`timescale 1ns/1ps
module cbp_parser_bench;
  import cbp_pkg::*;
  logic                 ref_clk, resetn, program_request_n, hold_n;
  logic                 cfg_clk_pin, cfg_din, init_in, init_out, init_oe, cfg_we;
  logic [ADDR_W-1:0]    cfg_addr, run_addr;
  logic [DATA_BITS-1:0] cfg_data, last;
  logic                 load_done, mode_explicit, err_id, err_align, err_crc;
  logic                 q[$];
  logic                 fr[$];
  logic [77:0]          got[$];
  logic [77:0]          exp[$];
  int                   n_fail, checks_done;

  // Hold line has a pull-up; either party may pull it low.
  assign init_in = hold_n & (init_oe ? init_out : 1'b1);

  cbp_parser u_dut (.ref_clk(ref_clk), .resetn(resetn), .cfg_clk_pin(cfg_clk_pin),
    .cfg_din(cfg_din), .program_request_n(program_request_n), .init_in(init_in),
    .init_out(init_out), .init_oe(init_oe), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_data(cfg_data), .load_done(load_done), .mode_explicit(mode_explicit),
    .err_id(err_id), .err_align(err_align), .err_crc(err_crc));
  cbp_src src (.ref_clk(ref_clk), .cfg_clk_pin(cfg_clk_pin), .cfg_din(cfg_din));

  // ***************************************************************
  // Clock, monitor and checking
  // ***************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Every write strobe is logged mid-cycle, well clear of the edge that launches it.
  always @(negedge ref_clk) if (cfg_we === 1'b1) got.push_back({cfg_addr, cfg_data});

  function automatic logic [77:0] stat();
    return 78'({load_done, mode_explicit, err_id, err_align, err_crc, init_oe});
  endfunction

  task automatic check(input logic [77:0] seen, input logic [77:0] want);
    checks_done++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic finish_test();
    $display("fails=%0d checks=%0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ***************************************************************
  // Stream builders
  // ***************************************************************
  task automatic put(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) fr.push_back(v[i]);
  endtask

  task automatic flush();
    q = {q, fr};
    fr = {};
  endtask

  // Checksum is the byte sum of the frame so far, start pair included.
  task automatic close(input logic [7:0] flip, input logic [7:0] stop);
    logic [7:0] s;
    logic [7:0] b;
    s = 8'h00;
    b = 8'h00;
    foreach (fr[i]) begin
      b = {b[6:0], fr[i]};
      if (i % 8 == 7) s = s + b;
    end
    put(64'(s ^ flip), 8);
    put(64'(stop), 8);
    flush();
  endtask

  task automatic hdr(input logic [23:0] len, input logic [1:0] mode, input logic [19:0] idv);
    put(64'hff2, 12);
    put(64'(len), 24);
    put(64'hff, 8);
    flush();
    put(64'h1, 2);
    put(64'h3fff, 14);
    put(64'(mode), 2);
    put(64'h0, 42);
    put(64'(idv), 20);
    close(8'h00, 8'hff);
    run_addr = 14'h0;
  endtask

  task automatic dframe(input logic [63:0] d, input logic [7:0] flip, input logic [7:0] stop,
                        input logic keep);
    put(64'h1, 2);
    put(d, 64);
    put(64'h0, 6);
    close(flip, stop);
    last = d;
    if (keep) begin
      exp.push_back({run_addr, d});
      run_addr++;
    end
  endtask

  task automatic aframe(input logic [13:0] a);
    put(64'h0, 2);
    put(64'(a), 14);
    close(8'h00, 8'hff);
    exp.push_back({a, last});
  endtask

  task automatic post();
    put(64'h0, 2);
    put(64'h3fff, 14);
    put(64'hff, 8);
    put(64'hffff, 16);
    flush();
  endtask

  // Sends the stream at a random pace, then compares every logged write.
  task automatic go(input logic want_done);
    src.send(q, 4 + int'($urandom % 3));
    q = {};
    for (int i = 0; i < 40 && load_done !== want_done; i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    #1;
    // A load that never settles as expected ends the run as a mismatch.
    if (load_done !== want_done) begin
      n_fail++;
      finish_test();
    end
    while (got.size() > 0 || exp.size() > 0)
      check(got.size() > 0 ? got.pop_front() : '1, exp.size() > 0 ? exp.pop_front() : '0);
  endtask

  task automatic restart();
    program_request_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 program_request_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 check(stat(), 78'h0);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  initial begin
    n_fail = 0;
    checks_done = 0;
    resetn = 1'b0;
    program_request_n = 1'b1;
    hold_n = 1'b1;
    void'($urandom(94));
    repeat (3) @(posedge ref_clk);
    #1 resetn = 1'b1;
    check(stat(), 78'h0);
    repeat (4) @(posedge ref_clk);
    #1 hdr(24'h0, MODE_AUTO, DEVICE_ID);
    dframe(64'h0, 8'h00, 8'hff, 1'b1);
    dframe('1, 8'h00, 8'hff, 1'b1);
    dframe({$urandom, $urandom}, 8'h00, 8'hff, 1'b1);
    post();
    go(1'b1);
    check(stat(), 78'(6'h20));
    restart();
    hdr(24'h0, MODE_EXPL, DEVICE_ID);
    dframe({$urandom, $urandom}, 8'h00, 8'hff, 1'b0);
    aframe(14'($urandom % 16383));
    aframe(14'h3ffe);
    dframe({$urandom, $urandom}, 8'h00, 8'hff, 1'b0);
    aframe(14'h0);
    post();
    go(1'b1);
    check(stat(), 78'(6'h30));
    // Bad checksum parks the loader; the later frame is ignored.
    restart();
    hdr(24'h0, MODE_AUTO, DEVICE_ID);
    dframe({$urandom, $urandom}, 8'h00, 8'hff, 1'b1);
    dframe({$urandom, $urandom}, 8'(1 + $urandom % 255), 8'hff, 1'b0);
    dframe({$urandom, $urandom}, 8'h00, 8'hff, 1'b0);
    post();
    go(1'b0);
    check(stat(), 78'(6'h03));
    // A zero among the stop bits is caught at the next start pair.
    restart();
    hdr(24'h0, MODE_AUTO, DEVICE_ID);
    dframe({$urandom, $urandom}, 8'h00, 8'hef, 1'b1);
    dframe({$urandom, $urandom}, 8'h00, 8'hff, 1'b0);
    post();
    go(1'b0);
    check(stat(), 78'(6'h05));
    // Wrong identity, then an unknown mode code.
    for (int i = 0; i < 2; i++) begin
      restart();
      hdr(24'h0, i == 0 ? MODE_AUTO : 2'h2, i == 0 ? DEVICE_ID ^ 20'h1 : DEVICE_ID);
      dframe({$urandom, $urandom}, 8'h00, 8'hff, 1'b0);
      post();
      go(1'b0);
      check(stat(), 78'(6'h09));
    end
    // A held hold line or program request keeps the whole stream out.
    for (int i = 0; i < 2; i++) begin
      // The hold line must already be low when the loader leaves idle.
      if (i == 0) hold_n = 1'b0;
      restart();
      if (i != 0) program_request_n = 1'b0;
      hdr(24'h0, MODE_AUTO, DEVICE_ID);
      dframe({$urandom, $urandom}, 8'h00, 8'hff, 1'b0);
      post();
      go(1'b0);
      check(stat(), 78'h0);
      hold_n = 1'b1;
      program_request_n = 1'b1;
    end
    // A short length ends the load before the data frame lands.
    restart();
    hdr(24'd100, MODE_AUTO, DEVICE_ID);
    dframe({$urandom, $urandom}, 8'h00, 8'hff, 1'b0);
    go(1'b1);
    check(stat(), 78'(6'h20));
    finish_test();
  end

  // A hung run is cut short and counted as a mismatch.
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_fail++;
    finish_test();
  end
endmodule // cbp_parser_bench

bind cbp_parser cbp_parser_chk u_chk (.ref_clk(ref_clk), .resetn(resetn),
  .program_request_n(program_request_n), .init_out(init_out), .init_oe(init_oe),
  .cfg_we(cfg_we), .load_done(load_done), .mode_explicit(mode_explicit),
  .err_id(err_id), .err_align(err_align), .err_crc(err_crc));
